// ---- sim/fsq_props.sv ----
// checker of the fsq_top port behaviour
`timescale 1ns/1ps
module fsq_props (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic o_s_axi_awready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic o_falling_event,
   input wire logic o_falling_immediate,
   input wire logic o_falling_delayed
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence b_wait;
      o_s_axi_bvalid && !i_s_axi_bready;
   endsequence
   sequence r_wait;
      o_s_axi_rvalid && !i_s_axi_rready;
   endsequence
   bvalid_hold_a: assert property (b_wait |=> o_s_axi_bvalid
      && $stable(o_s_axi_bresp)) else $error("write answer dropped");
   rvalid_hold_a: assert property (r_wait |=> o_s_axi_rvalid
      && $stable(o_s_axi_rdata)) else $error("read answer dropped");
   rdata_upper_a: assert property (
      o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   aw_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
      else $error("write taken while answering");
   ar_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("read taken while answering");
   imm_event_a: assert property (
      o_falling_immediate |-> o_falling_event)
      else $error("level request without event");
   dly_event_a: assert property (
      o_falling_delayed |-> o_falling_event)
      else $error("delayed request without event");
   event_cause_a: assert property (
      o_falling_event |-> o_falling_immediate || o_falling_delayed)
      else $error("event without request");
   dly_pulse_a: assert property (
      $rose(o_falling_delayed) |=> !o_falling_delayed)
      else $error("delayed pulse too long");
endmodule
bind fsq_top fsq_props u_fsq_props (.i_sys_clk, .i_rst_n,
   .o_s_axi_awready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
   .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready,
   .o_falling_event, .o_falling_immediate, .o_falling_delayed);

// ---- sim/fsq_src_model.sv ----
// model of the peripheral outputs feeding the falling sources
`timescale 1ns/1ps
module fsq_src_model (
   input wire logic [15:0] i_drive_low,
   output logic [15:0] o_src
);
   // ----------------------------------------
   // source lines idle high, pulled low on command
   // ----------------------------------------
   assign o_src = ~i_drive_low;
endmodule

// ---- sim/tb_top.sv ----
// testbench of the falling event source qualifier
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
   err_count++; $display("mismatch at %0t: value differs", $time); end end
module tb_top;
   logic clk = 0;
   logic rst_n = 0;
   logic [4:0] awaddr = 0;
   logic [4:0] araddr = 0;
   logic [31:0] wdata = 0;
   logic awv = 0;
   logic wv = 0;
   logic bready = 0;
   logic arv = 0;
   logic rready = 0;
   logic [15:0] drv_low = 0;
   logic [15:0] src;
   logic awr, wr_rdy, bvalid, arr, rvalid, ev, imm, dly;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, v;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int n, d;
   localparam logic [1:0] OK = fsq_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = fsq_pkg::RESP_SLVERR;
   // ----------------------------------------
   // clock, parts and watchers
   // ----------------------------------------
   always #12.5 clk = ~clk;
   fsq_src_model u_fsq_src_model (.i_drive_low(drv_low), .o_src(src));
   fsq_top u_fsq_top (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_generator_input_pin_select(src[0]), .i_comparator_out(src[4:1]),
      .i_capture_unit_one(src[5]), .i_capture_unit_two(src[6]),
      .i_pulse_output_three(src[7]), .i_pulse_output_four(src[8]),
      .i_pulse_output_five(src[9]), .i_pulse_output_six(src[10]),
      .i_logic_cell_one(src[11]), .i_logic_cell_two(src[12]),
      .i_logic_cell_three(src[13]), .i_modulator_one_output(src[14]),
      .i_modulator_two_output(src[15]), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
      .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .o_falling_event(ev), .o_falling_immediate(imm),
      .o_falling_delayed(dly));
   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready) `CHK(bresp, bq.pop_front())
      if (rvalid === 1'b1 && rready) `CHK({rresp, rdata}, rq.pop_front())
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude;
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wr(input logic [4:0] a, input logic [31:0] x,
      input logic [1:0] r);
      bit aw_p = 1;
      bit w_p = 1;
      bq.push_back(r);
      awaddr <= a;
      wdata <= x;
      awv <= 1;
      wv <= 1;
      while (aw_p || w_p) begin
         @(posedge clk);
         aw_p &= (awr !== 1'b1);
         w_p &= (wr_rdy !== 1'b1);
         awv <= aw_p;
         wv <= w_p;
      end
      repeat ($urandom_range(2)) @(posedge clk);
      bready <= 1;
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [33:0] e);
      rq.push_back(e);
      araddr <= a;
      arv <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0;
      repeat ($urandom_range(2)) @(posedge clk);
      rready <= 1;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 0;
   endtask
   task automatic wr_cfg(input logic [31:0] cfg);
      for (int i = 0; i < 4; i++) wr(5'(4 * i), 32'(cfg[8*i +: 8]), OK);
   endtask
   task automatic wait_ev(input int m, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((m ? dly : imm) !== 1'b1 && k < 12);
   endtask
   task conclude;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(64));
      repeat (8) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rd(5'(4 * i), {OK, 32'h00000000});
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(5'(4 * i), v, OK);
         rd(5'(4 * i), {OK, 24'h000000, v[7:0]});
      end
      wr(5'h14, $urandom, ERR);
      rd(5'h14, {ERR, 32'h00000000});
      d = $urandom_range(5, 1);
      wr(5'(fsq_pkg::ADDR_PHASE_BYTE), 32'(d), OK);
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 16; s++) begin
            wr_cfg({{16{m[0]}}, 16'(1 << s)});
            @(posedge clk);
            drv_low <= 16'(1 << ((s + 1) % 16));
            wait_ev(m, n);
            `CHK(n, 12)
            `CHK(ev, 1'b0)
            @(posedge clk);
            drv_low <= 0;
            repeat (4) @(posedge clk);
            drv_low <= 16'(1 << s);
            wait_ev(m, n);
            `CHK(n, m ? 6 + d : 4)
            `CHK(m ? imm : dly, 1'b0)
            `CHK(ev, 1'b1)
            if (m) wait_ev(1, n);
            if (m) `CHK(n, 12)
            @(posedge clk);
            drv_low <= 0;
            repeat (6) @(posedge clk);
         end
      end
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rd(5'(4 * i), {OK, 32'h00000000});
      conclude;
   end
endmodule

// ---- verilog/fsq_delay.sv ----
// falling event phase delay counter
`timescale 1ns/1ps
module fsq_delay #(
   parameter int CNT_WIDTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [CNT_WIDTH-1:0] i_delay,
   output logic o_done
);
   logic [CNT_WIDTH-1:0] cnt_q;
   logic busy_q;

   // delay of zero gives the event two cycles after the edge
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_q <= i_delay;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == '0) begin
               busy_q <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule

// ---- verilog/fsq_pkg.sv ----
// package of constants for the falling event source qualifier
package fsq_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [3:0] ADDR_ENABLE_LOW = 4'h0;
   localparam logic [3:0] ADDR_ENABLE_HIGH = 4'h4;
   localparam logic [3:0] ADDR_MODE_LOW = 4'h8;
   localparam logic [3:0] ADDR_MODE_HIGH = 4'hC;
   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int NUM_SOURCES = 16;
   localparam int REG_WIDTH = 8;
   localparam int TOP_SOURCE = 15;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // falling event phase delay in generator clocks
   // ----------------------------------------
   localparam logic [7:0] PHASE_DELAY_RESET = 8'h00;
   localparam logic [3:0] ADDR_PHASE_DELAY = 4'h0;
   localparam logic [7:0] ADDR_PHASE_BYTE = 8'h10;
endpackage

// ---- verilog/fsq_sync.sv ----
// two flip-flop synchroniser bank for the falling sources
`timescale 1ns/1ps
module fsq_sync #(
   parameter int WIDTH = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '1;
         o_sync <= '1;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

// ---- verilog/fsq_top.sv ----
// falling event source qualifier with AXI4-Lite register slave
// What this block does
// [R01] enable bit one lets source act
// [R02] upper enable bits map sources eight-fifteen
// [R03] edge mode: falling edge after delay
// [R04] level mode: low level immediate event
// [R05] disabled source ignores its mode bit
// [R06] lower mode bits map sources zero-seven
// [R07] upper mode bits map sources eight-fifteen
// [R08] source fifteen bits only on large variant
// [R09] all bits read-write, reset to zero
// [R10] source zero is selected input pin
// [R11] lower enable bits map sources zero-seven
// [R12] qualified requests combined by OR
// [R13] edge found from previous sample
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module fsq_top #(
   parameter bit HAS_TOP_SOURCE = 1'b1,
   parameter int DELAY_WIDTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // source 0 pin, 1-4 comparators, 5-6 capture, 7-10 pulse outputs,
   // 11-13 logic cells, 14-15 modulators
   input wire logic i_generator_input_pin_select,
   input wire logic [3:0] i_comparator_out,
   input wire logic i_capture_unit_one,
   input wire logic i_capture_unit_two,
   input wire logic i_pulse_output_three,
   input wire logic i_pulse_output_four,
   input wire logic i_pulse_output_five,
   input wire logic i_pulse_output_six,
   input wire logic i_logic_cell_one,
   input wire logic i_logic_cell_two,
   input wire logic i_logic_cell_three,
   input wire logic i_modulator_one_output,
   input wire logic i_modulator_two_output,
   input wire logic [4:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [4:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic o_falling_event,
   output logic o_falling_immediate,
   output logic o_falling_delayed
);
   localparam int NS = fsq_pkg::NUM_SOURCES;
   localparam int RW = fsq_pkg::REG_WIDTH;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [RW-1:0] enable_low_q;
   logic [RW-1:0] falling_source_enable_high_q;
   logic [RW-1:0] falling_source_mode_low_q;
   logic [RW-1:0] falling_source_mode_high_q;
   logic [DELAY_WIDTH-1:0] phase_delay_q;
   logic [NS-1:0] enable_w;
   logic [NS-1:0] mode_w;
   logic [RW-1:0] impl_mask_w;

   // source fifteen bits are absent on small variants
   assign impl_mask_w = HAS_TOP_SOURCE ? 8'hFF : 8'h7F; // [R08]
   // [R11] [R02] [R06] [R07]
   assign enable_w = {falling_source_enable_high_q, enable_low_q};
   assign mode_w = {falling_source_mode_high_q, falling_source_mode_low_q};

   // ----------------------------------------
   // source gathering and synchronising
   // ----------------------------------------
   logic [NS-1:0] src_raw_w;
   logic [NS-1:0] src_sync_w;
   logic [NS-1:0] src_prev_q;

   assign src_raw_w = {i_modulator_two_output, i_modulator_one_output,
                       i_logic_cell_three, i_logic_cell_two,
                       i_logic_cell_one, i_pulse_output_six,
                       i_pulse_output_five, i_pulse_output_four,
                       i_pulse_output_three, i_capture_unit_two,
                       i_capture_unit_one, i_comparator_out,
                       i_generator_input_pin_select}; // [R10]

   fsq_sync #(
      .WIDTH(NS)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async(src_raw_w),
      .o_sync(src_sync_w)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         src_prev_q <= '1;
      end else begin
         src_prev_q <= src_sync_w; // [R13]
      end
   end

   // ----------------------------------------
   // qualification
   // ----------------------------------------
   logic [NS-1:0] edge_req_w;
   logic [NS-1:0] level_req_w;
   logic edge_any_w;
   logic level_any_w;
   logic delay_done_w;

   // falling edge with enable and edge mode
   assign edge_req_w = enable_w & mode_w & src_prev_q & ~src_sync_w; // [R03]
   // low level with enable and level mode
   assign level_req_w = enable_w & ~mode_w & ~src_sync_w; // [R04]
   // disabled sources drop out of both terms above  [R01] [R05]
   assign edge_any_w = |edge_req_w; // [R12]
   assign level_any_w = |level_req_w; // [R12]

   fsq_delay #(
      .CNT_WIDTH(DELAY_WIDTH)
   ) u_delay (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_start(edge_any_w),
      .i_delay(phase_delay_q),
      .o_done(delay_done_w)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_falling_immediate <= 1'b0;
         o_falling_delayed <= 1'b0;
         o_falling_event <= 1'b0;
      end else begin
         o_falling_immediate <= level_any_w; // [R04]
         o_falling_delayed <= delay_done_w; // [R03]
         o_falling_event <= level_any_w | delay_done_w; // [R12]
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   logic aw_have_q;
   logic w_have_q;
   logic [4:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write_w;

   assign do_write_w = aw_have_q && w_have_q && !o_s_axi_bvalid;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         o_s_axi_awready <= 1'b0;
      end else begin
         // no new address while a write answer waits
         o_s_axi_awready <= !aw_have_q && !o_s_axi_awready
                            && !o_s_axi_bvalid;
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
         end else if (do_write_w) begin
            aw_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         o_s_axi_wready <= 1'b0;
      end else begin
         o_s_axi_wready <= !w_have_q && !o_s_axi_wready
                           && !o_s_axi_bvalid;
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= i_s_axi_wdata;
            w_strb_q <= i_s_axi_wstrb;
            o_s_axi_wready <= 1'b0;
         end else if (do_write_w) begin
            w_have_q <= 1'b0;
         end
      end
   end

   function automatic logic is_mapped(input logic [4:0] addr);
      is_mapped = (addr[1:0] == 2'h0) && (addr <= 5'h10);
   endfunction

   // ----------------------------------------
   // register address decoding
   // ----------------------------------------
   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_ENABLE_LOW = 3'h1,
      SEL_ENABLE_HIGH = 3'h2,
      SEL_MODE_LOW = 3'h3,
      SEL_MODE_HIGH = 3'h4,
      SEL_PHASE = 3'h5
   } fsq_reg_sel_e;

   // one decoder shared by the write and the read path
   function automatic fsq_reg_sel_e decode_reg(input logic [4:0] addr);
      if (addr == {1'b0, fsq_pkg::ADDR_ENABLE_LOW}) begin
         decode_reg = SEL_ENABLE_LOW;
      end else if (addr == {1'b0, fsq_pkg::ADDR_ENABLE_HIGH}) begin
         decode_reg = SEL_ENABLE_HIGH;
      end else if (addr == {1'b0, fsq_pkg::ADDR_MODE_LOW}) begin
         decode_reg = SEL_MODE_LOW;
      end else if (addr == {1'b0, fsq_pkg::ADDR_MODE_HIGH}) begin
         decode_reg = SEL_MODE_HIGH;
      end else if (addr == fsq_pkg::ADDR_PHASE_BYTE[4:0]) begin
         decode_reg = SEL_PHASE;
      end else begin
         decode_reg = SEL_NONE;
      end
   endfunction

   logic wr_hit_w;
   logic wr_en_w;
   fsq_reg_sel_e wr_sel_w;
   assign wr_hit_w = is_mapped(aw_addr_q);
   assign wr_en_w = do_write_w && wr_hit_w && w_strb_q[0];
   assign wr_sel_w = decode_reg(aw_addr_q);

   // ----------------------------------------
   // register bank, one process per register
   // ----------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enable_low_q <= fsq_pkg::REG_RESET; // [R09]
      end else if (wr_en_w && wr_sel_w == SEL_ENABLE_LOW) begin // [R11]
         enable_low_q <= w_data_q[7:0]; // [R09]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         falling_source_enable_high_q <= fsq_pkg::REG_RESET; // [R09]
      end else if (wr_en_w && wr_sel_w == SEL_ENABLE_HIGH) begin // [R02]
         falling_source_enable_high_q <= w_data_q[7:0] & impl_mask_w;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         falling_source_mode_low_q <= fsq_pkg::REG_RESET; // [R09]
      end else if (wr_en_w && wr_sel_w == SEL_MODE_LOW) begin // [R06]
         falling_source_mode_low_q <= w_data_q[7:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         falling_source_mode_high_q <= fsq_pkg::REG_RESET; // [R09]
      end else if (wr_en_w && wr_sel_w == SEL_MODE_HIGH) begin // [R07]
         falling_source_mode_high_q <= w_data_q[7:0] & impl_mask_w;
      end
   end

   // phase delay only paces the edge mode sources
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_delay_q <= fsq_pkg::PHASE_DELAY_RESET;
      end else if (wr_en_w && wr_sel_w == SEL_PHASE) begin
         phase_delay_q <= w_data_q[DELAY_WIDTH-1:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= fsq_pkg::RESP_OKAY;
      end else if (do_write_w) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp <= wr_hit_w ? fsq_pkg::RESP_OKAY
                                   : fsq_pkg::RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   logic [7:0] rd_byte_w;
   fsq_reg_sel_e rd_sel_w;

   assign rd_sel_w = decode_reg(i_s_axi_araddr);

   always_comb begin
      rd_byte_w = 8'h00;
      if (rd_sel_w == SEL_ENABLE_LOW) begin
         rd_byte_w = enable_low_q;
      end else if (rd_sel_w == SEL_ENABLE_HIGH) begin
         rd_byte_w = falling_source_enable_high_q;
      end else if (rd_sel_w == SEL_MODE_LOW) begin
         rd_byte_w = falling_source_mode_low_q;
      end else if (rd_sel_w == SEL_MODE_HIGH) begin
         rd_byte_w = falling_source_mode_high_q;
      end else if (rd_sel_w == SEL_PHASE) begin
         rd_byte_w = 8'(phase_delay_q);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= '0;
         o_s_axi_rresp <= fsq_pkg::RESP_OKAY;
      end else begin
         o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= {24'h000000, rd_byte_w};
            o_s_axi_rresp <= is_mapped(i_s_axi_araddr) ? fsq_pkg::RESP_OKAY
                                                       : fsq_pkg::RESP_SLVERR;
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
